// ===== common/gpio_route_consts.svh
// Offsets, field positions, reset values and limits of the GPIO pin routing block
`ifndef GPIO_ROUTE_CONSTS_SVH
`define GPIO_ROUTE_CONSTS_SVH

`define GPR_ADDR_WIDTH 12
`define GPR_DATA_WIDTH 32
`define GPR_ROUTE_OFFSET 12'h62C
`define GPR_IN_DATA_OFFSET 12'h63C
`define GPR_OUT_DATA_OFFSET 12'h644
`define GPR_ROUTE_RESET 32'h0000_0000
`define GPR_IN_DATA_RESET 16'h0000
`define GPR_READ_ZERO 32'h0000_0000
`define GPR_REG_PINS 16
`define GPR_DEFAULT_PINS 12
`define GPR_SEL_BIT 0
`define GPR_DIR_BIT 1
`define GPR_FIELD_BITS 2

`endif

// ===== common/gpio_route_pkg.sv
// Types shared by the GPIO pin routing block
package gpio_route_pkg;

  // One configuration space access as issued by the port's register logic
  typedef struct packed {
    logic write;
    logic read;
    logic [11:0] addr;
    logic [31:0] wrData;
    logic [3:0] byteEn;
  } cfg_req_t;

  // Answer to a configuration read
  typedef struct packed {
    logic rdValid;
    logic [31:0] rdData;
  } cfg_rsp_t;

  // Routing field of one pin
  typedef struct packed {
    logic dir;
    logic sel;
  } pin_route_t;

endpackage

// ===== logic/gpio_pin_cell.sv
// One GPIO pin: input synchroniser, routing of the input and selection of the output source
`timescale 1ns/1ns
`default_nettype none

module gpio_pin_cell (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire gpio_route_pkg::pin_route_t route,
  input wire logic pinIn,
  input wire logic outData,
  input wire logic hotPlugReset,
  output logic pinOut,
  output logic pinOe_n,
  output logic inData,
  output logic intReq
);

  logic syncA_reg;
  logic syncB_reg;

  // Pin is asynchronous to the core clock; only syncB_reg is read downstream
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
    end else begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
    end
  end

  // Input side: data register path or interrupt path, zero while driving
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      inData <= 1'b0;
      intReq <= 1'b0;
    end else begin
      inData <= !route.dir && !route.sel && syncB_reg;
      intReq <= !route.dir && route.sel && syncB_reg;
    end
  end

  // Output side: enable released while input, so the board can drive the pin
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pinOe_n <= 1'b1;
      pinOut <= 1'b0;
    end else begin
      pinOe_n <= !route.dir;
      pinOut <= route.sel ? hotPlugReset : outData;
    end
  end

  chk_oe_follows_dir: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 (pinOe_n == !$past(route.dir)))
    else $error("pin enable does not follow direction");

  chk_out_data_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (route.dir && !route.sel) |=> (pinOut == $past(outData)) && !pinOe_n)
    else $error("output pin not driven from output data");

  chk_out_reset_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (route.dir && route.sel) |=> (pinOut == $past(hotPlugReset)) && !pinOe_n)
    else $error("output pin not driven from hot-plug reset");

  chk_in_data_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!route.dir && !route.sel) |=> (inData == $past(syncB_reg)) && !intReq)
    else $error("input pin state missing from input data");

  chk_in_int_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!route.dir && route.sel) |=> (intReq == $past(syncB_reg)) && !inData)
    else $error("input pin not routed to interrupt");

  chk_output_reads_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    route.dir |=> !inData && !intReq)
    else $error("output pin leaks into input paths");

endmodule

`default_nettype wire

// ===== logic/gpio_pin_routing_direction.sv
// GPIO pin routing and direction register with per-pin routing of every pin
`timescale 1ns/1ns
`default_nettype none
`include "gpio_route_consts.svh"

module gpio_pin_routing_direction #(
  parameter int PIN_COUNT = `GPR_DEFAULT_PINS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  // Set when this instance sits in the upstream port
  input wire logic isUpstreamPort,
  // Configuration space access from the port's register logic
  input wire gpio_route_pkg::cfg_req_t cfgReq,
  output gpio_route_pkg::cfg_rsp_t cfgRsp,
  // Output data register contents, kept elsewhere
  input wire logic [PIN_COUNT-1:0] outDataBits,
  // Serial hot-plug reset of each hot-plug port, index equals port number
  input wire logic [PIN_COUNT-1:0] hotPlugReset,
  // Pins
  input wire logic [PIN_COUNT-1:0] pinIn,
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOe_n,
  // Pin states for the input data register
  output logic [PIN_COUNT-1:0] inDataBits,
  // Pins routed to the general interrupt, one level per pin
  output logic [PIN_COUNT-1:0] intReqBits,
  // Any routed pin requesting; feeds the INTx, MSI and host_interrupt_pin logic
  output logic generalIntReq
);

  localparam int FIELD_BITS = `GPR_FIELD_BITS;
  localparam int USED_BITS = FIELD_BITS * PIN_COUNT;
  localparam int DATA_W = `GPR_DATA_WIDTH;

  // The register only holds fields for sixteen pins, so a wider port has nowhere
  // to keep its routing; refuse it while the design is being built
  if (PIN_COUNT < 1 || PIN_COUNT > `GPR_REG_PINS || USED_BITS > DATA_W) begin : g_bad_pins
    $error("PIN_COUNT must lie between 1 and 16");
  end

  // Only fields of implemented pins are writable; the rest read as zero
  function automatic logic [31:0] usedMask();
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < USED_BITS; i++) begin
      m[i] = 1'b1;
    end
    return m;
  endfunction

  localparam logic [31:0] ROUTE_MASK = usedMask();

  logic [31:0] routeReg;
  logic [31:0] routeNext;
  logic [31:0] byteMask;
  logic routeHit;
  logic inDataHit;
  logic [31:0] inDataWord;
  logic [31:0] rdDataNext;
  logic [PIN_COUNT-1:0] dirBits;

  // Decode; the routing register exists only in the upstream port
  assign routeHit = isUpstreamPort && (cfgReq.addr == `GPR_ROUTE_OFFSET);
  assign inDataHit = cfgReq.addr == `GPR_IN_DATA_OFFSET;

  // Expand byte enables to a bit mask for partial writes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byteMask[8*b +: 8] = {8{cfgReq.byteEn[b]}};
    end
  end

  // Merge written bytes into the current value, keeping unimplemented fields zero
  always_comb begin
    routeNext = routeReg;
    if (cfgReq.write && routeHit) begin
      routeNext = ((cfgReq.wrData & byteMask) | (routeReg & ~byteMask)) & ROUTE_MASK;
    end
  end

  // Routing register; reset makes every pin a data input
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      routeReg <= `GPR_ROUTE_RESET;
    end else begin
      routeReg <= routeNext;
    end
  end

  // Input data word: bits of unimplemented pins read as zero
  always_comb begin
    inDataWord = `GPR_READ_ZERO;
    inDataWord[PIN_COUNT-1:0] = inDataBits;
  end

  // Read mux; an unmapped or absent register answers zero, never stalls
  always_comb begin
    rdDataNext = `GPR_READ_ZERO;
    if (routeHit) begin
      rdDataNext = routeReg;
    end else if (inDataHit) begin
      rdDataNext = inDataWord;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfgRsp.rdValid <= 1'b0;
      cfgRsp.rdData <= `GPR_READ_ZERO;
    end else begin
      cfgRsp.rdValid <= cfgReq.read;
      cfgRsp.rdData <= cfgReq.read ? rdDataNext : `GPR_READ_ZERO;
    end
  end

  // One cell per pin; pin n takes field n and hot-plug reset n
  for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
    gpio_route_pkg::pin_route_t route;

    assign route.dir = routeReg[FIELD_BITS*n + `GPR_DIR_BIT];
    assign route.sel = routeReg[FIELD_BITS*n + `GPR_SEL_BIT];

    gpio_pin_cell gpio_pin_cell_inst (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .route(route),
      .pinIn(pinIn[n]),
      .outData(outDataBits[n]),
      .hotPlugReset(hotPlugReset[n]),
      .pinOut(pinOut[n]),
      .pinOe_n(pinOe_n[n]),
      .inData(inDataBits[n]),
      .intReq(intReqBits[n])
    );
  end

  // Direction bits of all pins side by side, read only by the whole-port checks
  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      dirBits[p] = routeReg[FIELD_BITS*p + `GPR_DIR_BIT];
    end
  end

  // Combined request; the interrupt logic downstream picks INTx, MSI or pin
  assign generalIntReq = |intReqBits;

  chk_reset_clears_route: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reset_n && !$past(reset_n)) |-> (routeReg == `GPR_ROUTE_RESET) && (&pinOe_n))
    else $error("routing not cleared or pin driven after reset");

  chk_route_write_lands: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfgReq.write && isUpstreamPort && cfgReq.addr == `GPR_ROUTE_OFFSET
      && cfgReq.byteEn == 4'hF)
    |=> routeReg == ($past(cfgReq.wrData) & ROUTE_MASK))
    else $error("full write to routing register lost");

  chk_downstream_no_route: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !isUpstreamPort |=> $stable(routeReg))
    else $error("routing register changed outside upstream port");

  chk_read_route_back: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfgReq.read && !cfgReq.write && routeHit)
    |=> cfgRsp.rdValid && (cfgRsp.rdData == $past(routeReg)))
    else $error("routing register read answer wrong");

  chk_int_summary: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (routeReg == `GPR_ROUTE_RESET) ##1 (routeReg == `GPR_ROUTE_RESET) |-> !generalIntReq)
    else $error("interrupt requested with no pin routed to it");

  chk_pin11_reset_map: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (PIN_COUNT > 11 && routeReg[23] && routeReg[22])
    |=> pinOut[PIN_COUNT-1 < 11 ? 0 : 11] == $past(hotPlugReset[PIN_COUNT-1 < 11 ? 0 : 11]))
    else $error("pin 11 not driven by hot-plug port 11 reset");

  // Whole-port views: a pin is released exactly while its direction bit is clear
  chk_released_inputs: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 (pinOe_n == ~$past(dirBits)))
    else $error("pin driven while configured as input");

  chk_unused_fields_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (routeReg & ~ROUTE_MASK) == `GPR_READ_ZERO)
    else $error("field of an absent pin holds a one");

  chk_foreign_write_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfgReq.write && cfgReq.addr != `GPR_ROUTE_OFFSET) |=> $stable(routeReg))
    else $error("write to another offset changed the routing register");

  chk_idle_route_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfgReq.write |=> $stable(routeReg))
    else $error("routing register changed with no write");

  chk_read_idle_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfgReq.read |=> !cfgRsp.rdValid && (cfgRsp.rdData == `GPR_READ_ZERO))
    else $error("read answer without a read request");

  chk_downstream_read_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfgReq.read && !isUpstreamPort && cfgReq.addr == `GPR_ROUTE_OFFSET)
    |=> cfgRsp.rdValid && (cfgRsp.rdData == `GPR_READ_ZERO))
    else $error("routing register visible outside upstream port");

  chk_in_data_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfgReq.read && cfgReq.addr == `GPR_IN_DATA_OFFSET)
    |=> cfgRsp.rdValid && (cfgRsp.rdData[PIN_COUNT-1:0] == $past(inDataBits)))
    else $error("input data read answer wrong");

  // Input paths start quiet, so no false interrupt follows a reset
  chk_reset_inputs_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reset_n && !$past(reset_n))
    |-> ~|inDataBits && ~|intReqBits && !cfgRsp.rdValid)
    else $error("input paths not cleared by reset");

  chk_one_input_path: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ~|(inDataBits & intReqBits))
    else $error("pin feeds data and interrupt at once");

  chk_outputs_read_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 ~|($past(dirBits) & (inDataBits | intReqBits)))
    else $error("output pin visible in input paths");

endmodule

`default_nettype wire

// ===== test/gpio_board_model.sv
// Board-side model of the GPIO pins and the levels the board puts on them
`timescale 1ns/1ns
`default_nettype none

module gpio_board_model #(
  parameter int PINS = 12
) (
  input wire logic [PINS-1:0] boardLevel,
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOe_n,
  output logic [PINS-1:0] pinIn
);
  // Wire level: the switch wins while it drives, the board only where it is released
  always_comb begin
    for (int n = 0; n < PINS; n++) begin
      pinIn[n] = pinOe_n[n] ? boardLevel[n] : pinOut[n];
    end
  end
endmodule
`default_nettype wire

// ===== test/gpio_pin_routing_direction_tb.sv
// Self-checking bench for the GPIO pin routing and direction block
`timescale 1ns/1ns
`default_nettype none
`include "gpio_route_consts.svh"
`define CHK(what, exp, got) begin nTests++; if ((exp) !== (got)) begin nErrors++; \
  $display("BAD %s expected %h seen %h", what, exp, got); end end

module gpio_pin_routing_direction_tb;
  localparam int PINS = 12;
  localparam logic [31:0] MASK = (32'h0000_0001 << (2 * PINS)) - 32'h0000_0001;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic isUpstreamPort = 1'b1;
  gpio_route_pkg::cfg_req_t cfgReq = '0;
  gpio_route_pkg::cfg_rsp_t cfgRsp;
  logic [PINS-1:0] outDataBits = '0;
  logic [PINS-1:0] hotPlugReset = '0;
  logic [PINS-1:0] boardLevel = '0;
  logic [PINS-1:0] pinIn, pinOut, pinOe_n, inDataBits, intReqBits;
  logic generalIntReq;
  logic [15:0] lfsr = 16'h966a;
  logic [31:0] shadow, cfg, rd;
  logic [3:0] be;
  logic [PINS-1:0] oldIn;
  int nErrors = 0;
  int nTests = 0;

  // Core clock, 4 ns period
  always #2 ref_clk = ~ref_clk;

  gpio_pin_routing_direction #(.PIN_COUNT(PINS)) gpio_pin_routing_direction_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .isUpstreamPort(isUpstreamPort),
    .cfgReq(cfgReq), .cfgRsp(cfgRsp), .outDataBits(outDataBits),
    .hotPlugReset(hotPlugReset), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .inDataBits(inDataBits), .intReqBits(intReqBits), .generalIntReq(generalIntReq));

  gpio_board_model #(.PINS(PINS)) gpio_board_model_inst (
    .boardLevel(boardLevel), .pinOut(pinOut), .pinOe_n(pinOe_n), .pinIn(pinIn));

  // Sixteen-bit LFSR; two steps give one 32-bit value
  function automatic logic [31:0] rand32();
    logic [31:0] v;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v[15:0] = lfsr;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v[31:16] = lfsr;
    return v;
  endfunction

  // Expected pin view: 0 direction, 1 drive value, 2 data input, 3 interrupt input
  function automatic logic [PINS-1:0] expPin(input logic [31:0] c, input int kind);
    logic [PINS-1:0] r;
    for (int n = 0; n < PINS; n++) begin
      case (kind)
        0: r[n] = c[2*n+1];
        1: r[n] = c[2*n+1] && (c[2*n] ? hotPlugReset[n] : outDataBits[n]);
        2: r[n] = !c[2*n+1] && !c[2*n] && boardLevel[n];
        default: r[n] = !c[2*n+1] && c[2*n] && boardLevel[n];
      endcase
    end
    return r;
  endfunction

  // One-cycle requests launched on the falling edge, taken on the next rising one
  task automatic cfgWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge ref_clk);
    cfgReq = '{write: 1'b1, read: 1'b0, addr: a, wrData: d, byteEn: b};
    @(negedge ref_clk);
    cfgReq = '0;
  endtask

  // Read answer stands for one cycle only, so it is sampled in that cycle
  task automatic cfgRead(input logic [11:0] a, output logic [31:0] d);
    @(negedge ref_clk);
    cfgReq = '{write: 1'b0, read: 1'b1, addr: a, wrData: 32'h0000_0000, byteEn: 4'hf};
    @(negedge ref_clk);
    cfgReq = '0;
    `CHK("rdValid", 1'b1, cfgRsp.rdValid)
    d = cfgRsp.rdData;
  endtask

  task automatic finalReport();
    if (nErrors == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Guard against a hung run
  initial begin
    #40000;
    nErrors++;
    finalReport();
  end

  // Main sequence: corner layouts first, then random layouts and pin levels
  initial begin
    shadow = '0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    `CHK("pinOe_n after reset", {PINS{1'b1}}, pinOe_n)
    cfgRead(`GPR_ROUTE_OFFSET, rd);
    `CHK("route after reset", `GPR_ROUTE_RESET, rd)
    for (int i = 0; i < 24; i++) begin
      cfg = rand32();
      rd = rand32();
      outDataBits = rd[11:0];
      hotPlugReset = rd[23:12];
      be = (i < 4) ? 4'hf : rd[27:24];
      rd = rand32();
      boardLevel = rd[11:0];
      isUpstreamPort = (i != 3);
      case (i)
        0: cfg = 32'hffff_ffff;
        1: cfg = 32'h5555_5555;
        2: cfg = 32'haaaa_aaaa;
        default: ;
      endcase
      cfgWrite(`GPR_ROUTE_OFFSET, cfg, be);
      // Only the upstream port keeps the write, and only the enabled bytes
      for (int k = 0; k < 4; k++) begin
        if (be[k] && isUpstreamPort) shadow[8*k+:8] = cfg[8*k+:8];
      end
      shadow &= MASK;
      cfgRead(`GPR_ROUTE_OFFSET, rd);
      // Outside the upstream port the routing register reads as zero
      `CHK("route readback", isUpstreamPort ? shadow : `GPR_READ_ZERO, rd)
      repeat (6) @(negedge ref_clk);
      `CHK("pinOe_n", ~expPin(shadow, 0), pinOe_n)
      `CHK("pinOut", expPin(shadow, 1), pinOut & expPin(shadow, 0))
      `CHK("inDataBits", expPin(shadow, 2), inDataBits)
      `CHK("intReqBits", expPin(shadow, 3), intReqBits)
      `CHK("generalIntReq", |expPin(shadow, 3), generalIntReq)
      cfgRead(`GPR_IN_DATA_OFFSET, rd);
      `CHK("input data read", {20'h0_0000, expPin(shadow, 2)}, rd)
      // Pin level change reaches the input data bits on the third rising edge
      oldIn = expPin(shadow, 2);
      boardLevel = ~boardLevel;
      repeat (2) @(negedge ref_clk);
      `CHK("inDataBits before sync", oldIn, inDataBits)
      @(negedge ref_clk);
      `CHK("inDataBits after sync", expPin(shadow, 2), inDataBits)
    end
    // Writes to other offsets never reach the routing register
    cfgWrite(`GPR_IN_DATA_OFFSET, 32'hffff_ffff, 4'hf);
    cfgWrite(`GPR_OUT_DATA_OFFSET, 32'hffff_ffff, 4'hf);
    cfgWrite(12'h630, 32'hffff_ffff, 4'hf);
    cfgRead(`GPR_ROUTE_OFFSET, rd);
    `CHK("route after foreign writes", shadow, rd)
    cfgRead(12'h630, rd);
    `CHK("unmapped read", `GPR_READ_ZERO, rd)
    // Second reset with every pin driven: all must fall back to released inputs
    cfgWrite(`GPR_ROUTE_OFFSET, 32'haaaa_aaaa, 4'hf);
    repeat (2) @(negedge ref_clk);
    `CHK("pinOe_n before reset", {PINS{1'b0}}, pinOe_n)
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    `CHK("pinOe_n after second reset", {PINS{1'b1}}, pinOe_n)
    cfgRead(`GPR_ROUTE_OFFSET, rd);
    `CHK("route after second reset", `GPR_ROUTE_RESET, rd)
    finalReport();
  end
endmodule
`default_nettype wire
